/* File: hw/addr_space_pkg.sv */
package addr_space_pkg;
    // Bus widths
    localparam int PROG_ADDR_W = 16;
    localparam int REG_W = 8;
    // Program memory map
    localparam int PROG_KB_DEFAULT = 8;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0000;
    localparam logic [15:0] VEC_LO_ADDR = 16'h0001;
    localparam logic [15:0] OPT_SPARE0_ADDR = 16'h003C;
    localparam logic [15:0] OPT_SPARE1_ADDR = 16'h003D;
    localparam logic [15:0] OPT_LVR_ADDR = 16'h003E;
    localparam logic [15:0] OPT_OSC_ADDR = 16'h003F;
    localparam logic [15:0] RESET_PC = 16'h0100;
    localparam logic [7:0] OPT_ERASED = 8'hFF;
    localparam int OPT_LVR_BIT = 7;
    localparam logic [1:0] OSC_INTERNAL_RC = 2'h3;
    // Register file map
    localparam logic [7:0] GP_LAST = 8'hBF;
    localparam logic [7:0] WORK_FIRST = 8'hC0;
    localparam logic [7:0] WORK_LAST = 8'hCF;
    localparam logic [7:0] CTRL_FIRST = 8'hD0;
    localparam logic [7:0] CTRL_LAST = 8'hEF;
    localparam logic [7:0] STACK_TOP_POINTER_ADDR = 8'hD9;
    localparam int REG_STORE_BYTES = 208;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam logic [7:0] SP_WRAP = 8'hFF;
    // Stack requests from the core
    typedef enum logic [2:0] {
        STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_INT, STK_INTERRUPT_RETURN_OP
    } stack_op_t;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_OPT_LVR, ST_OPT_OSC, ST_IDLE, ST_PUSH, ST_POP, ST_VEC
    } seq_state_t;
endpackage : addr_space_pkg

/* File: hw/addr_space_regfile.sv */
`timescale 1ns/1ps
module addr_space_regfile #(
    parameter int PROG_KB = addr_space_pkg::PROG_KB_DEFAULT
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [addr_space_pkg::PROG_ADDR_W-1:0] prog_addr_in,
    input wire logic prog_rd_in,
    input wire logic prog_wr_in,
    input wire logic [7:0] prog_wdata_in,
    output logic prog_ready_out,
    output logic [7:0] prog_rdata_out,
    output logic prog_valid_out,
    output logic prog_err_out,
    output logic [15:0] start_pc_out,
    output logic boot_done_out,
    output logic lvr_enable_out,
    output logic [1:0] osc_select_out,
    output logic [7:0] opt_lvr_byte_out,
    output logic [7:0] opt_osc_byte_out,
    input wire logic [addr_space_pkg::REG_W-1:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic reg_pair_in,
    input wire logic reg_direct_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [15:0] reg_wdata16_in,
    output logic reg_ready_out,
    output logic [7:0] reg_rdata_out,
    output logic [15:0] reg_rdata16_out,
    output logic reg_ack_out,
    output logic reg_err_out,
    input wire addr_space_pkg::stack_op_t stack_op_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] push_data_in,
    output logic stack_ready_out,
    output logic stack_busy_out,
    output logic stack_done_out,
    output logic [15:0] pc_out,
    output logic pc_load_out,
    output logic [7:0] flags_out,
    output logic [7:0] pop_data_out,
    output logic [7:0] stack_top_pointer_out
);
    import addr_space_pkg::*;

    localparam int PROG_BYTES = PROG_KB * 1024;
    localparam int PA_W = $clog2(PROG_BYTES);
    localparam logic [15:0] PROG_LAST = 16'(PROG_BYTES - 1);

    // Only the two documented flash sizes are served
    if (PROG_KB != 8 && PROG_KB != 4) begin : g_bad_size
        $error("PROG_KB must be 4 or 8");
    end

    typedef struct packed {
        seq_state_t st;
        stack_op_t op;
        logic [7:0] sp;
        logic [1:0] idx;
        logic [15:0] pc;
        logic [7:0] flags;
        logic [7:0] pop_data;
        logic [7:0] opt_lvr;
        logic [7:0] opt_osc;
        logic [7:0] rdata;
        logic [15:0] rdata16;
        logic ack;
        logic err;
        logic [7:0] fetch;
        logic fetch_vld;
        logic fetch_err;
        logic pc_ld;
        logic done;
    } regs_t;

    localparam regs_t RESET_VAL = '{
        st: ST_OPT_LVR, op: STK_NONE, sp: SP_RESET, idx: 2'h0, pc: 16'h0000,
        flags: 8'h00, pop_data: 8'h00, opt_lvr: OPT_ERASED, opt_osc: OPT_ERASED,
        rdata: 8'h00, rdata16: 16'h0000, ack: 1'b0, err: 1'b0, fetch: 8'h00,
        fetch_vld: 1'b0, fetch_err: 1'b0, pc_ld: 1'b0, done: 1'b0};

    regs_t q, d;
    logic [7:0] prog_mem [0:PROG_BYTES-1];
    logic [7:0] reg_mem [0:REG_STORE_BYTES-1];
    logic we0, we1;
    logic [7:0] wa0, wa1, wd0, wd1;
    logic [7:0] sp_dec, pop_byte, a_lo, a_hi;
    logic bus_req, in_work, in_store, hi_store;

    // Bytes moved by each stack request, less one
    function automatic logic [1:0] last_idx(input stack_op_t op);
        case (op)
            STK_CALL, STK_RET: last_idx = 2'h1;
            STK_INT, STK_INTERRUPT_RETURN_OP: last_idx = 2'h2;
            default: last_idx = 2'h0;
        endcase
    endfunction : last_idx

    // Program fetches are refused only while options load
    assign prog_ready_out = (q.st != ST_OPT_LVR) && (q.st != ST_OPT_OSC);
    assign bus_req = reg_rd_in || reg_wr_in;
    assign reg_ready_out = (q.st == ST_IDLE);
    assign stack_ready_out = (q.st == ST_IDLE) && !bus_req;
    assign stack_busy_out = (q.st == ST_PUSH) || (q.st == ST_POP) || (q.st == ST_VEC);
    assign sp_dec = q.sp - 8'h01;
    // Page zero only: addresses below D0H hold storage
    assign a_lo = reg_addr_in;
    assign a_hi = {reg_addr_in[7:1], 1'b1};
    assign in_work = (a_lo >= WORK_FIRST) && (a_lo <= WORK_LAST);
    assign in_store = (a_lo < CTRL_FIRST);
    assign hi_store = (a_hi < CTRL_FIRST);
    assign pop_byte = (q.sp < CTRL_FIRST) ? reg_mem[q.sp] : 8'h00;

    // Next-state logic
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.err = 1'b0;
        d.fetch_vld = 1'b0;
        d.fetch_err = 1'b0;
        d.pc_ld = 1'b0;
        d.done = 1'b0;
        we0 = 1'b0;
        wa0 = 8'h00;
        wd0 = 8'h00;
        we1 = 1'b0;
        wa1 = 8'h00;
        wd1 = 8'h00;
        // Instruction fetch over the wide bus
        if (prog_ready_out && prog_rd_in) begin
            d.fetch_vld = 1'b1;
            if (prog_addr_in > PROG_LAST) begin
                d.fetch_err = 1'b1;
                d.fetch = 8'h00;
            end else begin
                d.fetch = prog_mem[prog_addr_in[PA_W-1:0]];
            end
        end
        case (q.st)
            // Option bytes are caught once after reset
            ST_OPT_LVR: begin
                d.opt_lvr = prog_mem[OPT_LVR_ADDR[PA_W-1:0]];
                d.st = ST_OPT_OSC;
            end
            ST_OPT_OSC: begin
                d.opt_osc = prog_mem[OPT_OSC_ADDR[PA_W-1:0]];
                d.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (bus_req) begin
                    d.ack = 1'b1;
                    if (reg_direct_in && in_work) begin
                        d.err = 1'b1;
                    end else if (reg_pair_in) begin
                        if (a_lo[0]) begin
                            d.err = 1'b1;
                        end else if (reg_rd_in) begin
                            d.rdata16[15:8] = in_store ? reg_mem[a_lo] : 8'h00;
                            d.rdata16[7:0] = hi_store ? reg_mem[a_hi] : 8'h00;
                        end else begin
                            we0 = in_store;
                            wa0 = a_lo;
                            wd0 = reg_wdata16_in[15:8];
                            we1 = hi_store;
                            wa1 = a_hi;
                            wd1 = reg_wdata16_in[7:0];
                        end
                    end else if (reg_rd_in) begin
                        // Control region: only the pointer lives here
                        if (in_store) begin
                            d.rdata = reg_mem[a_lo];
                        end else if (a_lo == STACK_TOP_POINTER_ADDR) begin
                            d.rdata = q.sp;
                        end else begin
                            d.rdata = 8'h00;
                        end
                    end else if (in_store) begin
                        we0 = 1'b1;
                        wa0 = a_lo;
                        wd0 = reg_wdata_in;
                    end else if (a_lo == STACK_TOP_POINTER_ADDR) begin
                        d.sp = reg_wdata_in;
                    end
                end else if (stack_op_in != STK_NONE) begin
                    d.op = stack_op_in;
                    d.idx = 2'h0;
                    d.pc = (stack_op_in == STK_PUSH) ? {8'h00, push_data_in} : pc_in;
                    d.flags = flags_in;
                    case (stack_op_in)
                        STK_PUSH, STK_CALL, STK_INT: d.st = ST_PUSH;
                        default: d.st = ST_POP;
                    endcase
                end
            end
            // One byte per cycle, pointer lowered first
            ST_PUSH: begin
                we0 = (sp_dec < CTRL_FIRST);
                wa0 = sp_dec;
                case (q.idx)
                    2'h0: wd0 = q.pc[7:0];
                    2'h1: wd0 = q.pc[15:8];
                    default: wd0 = q.flags;
                endcase
                d.sp = sp_dec;
                d.idx = q.idx + 2'h1;
                if (q.idx == last_idx(q.op)) begin
                    d.idx = 2'h0;
                    if (q.op == STK_INT) begin
                        d.st = ST_VEC;
                    end else begin
                        d.st = ST_IDLE;
                        d.done = 1'b1;
                    end
                end
            end
            // One byte per cycle, pointer raised after
            ST_POP: begin
                if (q.op == STK_POP) begin
                    d.pop_data = pop_byte;
                end else if (q.op == STK_INTERRUPT_RETURN_OP && q.idx == 2'h0) begin
                    d.flags = pop_byte;
                end else if (q.idx == last_idx(q.op)) begin
                    d.pc[7:0] = pop_byte;
                end else begin
                    d.pc[15:8] = pop_byte;
                end
                d.sp = q.sp + 8'h01;
                d.idx = q.idx + 2'h1;
                if (q.idx == last_idx(q.op)) begin
                    d.idx = 2'h0;
                    d.st = ST_IDLE;
                    d.done = 1'b1;
                    d.pc_ld = (q.op != STK_POP);
                end
            end
            // Single vector: high byte then low byte
            ST_VEC: begin
                d.pc = {prog_mem[VEC_HI_ADDR[PA_W-1:0]], prog_mem[VEC_LO_ADDR[PA_W-1:0]]};
                d.pc_ld = 1'b1;
                d.done = 1'b1;
                d.st = ST_IDLE;
            end
            default: d.st = ST_OPT_LVR;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= RESET_VAL;
        end else begin
            q <= d;
        end
    end

    // Flash starts erased, so unprogrammed bytes read FFH
    initial begin
        foreach (prog_mem[i]) prog_mem[i] = OPT_ERASED;
    end

    // Storage arrays; flash content comes from the programming port
    always_ff @(posedge clk_sys_in) begin
        if (prog_wr_in && prog_addr_in <= PROG_LAST) begin
            prog_mem[prog_addr_in[PA_W-1:0]] <= prog_wdata_in;
        end
        if (we0) begin
            reg_mem[wa0] <= wd0;
        end
        if (we1) begin
            reg_mem[wa1] <= wd1;
        end
    end

    // Outputs
    assign start_pc_out = RESET_PC;
    assign boot_done_out = prog_ready_out;
    assign prog_rdata_out = q.fetch;
    assign prog_valid_out = q.fetch_vld;
    assign prog_err_out = q.fetch_err;
    assign opt_lvr_byte_out = q.opt_lvr;
    assign opt_osc_byte_out = q.opt_osc;
    assign lvr_enable_out = q.opt_lvr[OPT_LVR_BIT];
    assign osc_select_out = q.opt_osc[1:0];
    assign reg_rdata_out = q.rdata;
    assign reg_rdata16_out = q.rdata16;
    assign reg_ack_out = q.ack;
    assign reg_err_out = q.err;
    assign stack_done_out = q.done;
    assign pc_out = q.pc;
    assign pc_load_out = q.pc_ld;
    assign flags_out = q.flags;
    assign pop_data_out = q.pop_data;
    assign stack_top_pointer_out = q.sp;

    // Checks
    sequence s_int_take;
        stack_ready_out && stack_op_in == STK_INT;
    endsequence
    sequence s_ret_take;
        stack_ready_out && stack_op_in == STK_RET;
    endsequence

    a_fetch_range: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        prog_ready_out && prog_rd_in && prog_addr_in > PROG_LAST |=> prog_err_out)
        else $error("out of range fetch not flagged");
    a_vector_load: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_int_take |=> stack_busy_out [*4] ##1 (pc_load_out && pc_out ==
            {prog_mem[VEC_HI_ADDR[PA_W-1:0]], prog_mem[VEC_LO_ADDR[PA_W-1:0]]}))
        else $error("vector not loaded high then low");
    a_boot_start: assert property (
        @(posedge clk_sys_in) $fell(rst_in) |-> !boot_done_out ##2
        (boot_done_out && start_pc_out == RESET_PC))
        else $error("boot does not finish in two cycles");
    a_opt_erased: assert property (
        @(posedge clk_sys_in) $fell(rst_in) |-> opt_lvr_byte_out == OPT_ERASED)
        else $error("option byte not erased default at reset");
    a_direct_refused: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_ready_out && reg_wr_in && reg_direct_in && in_work |=> reg_err_out)
        else $error("direct access to working area accepted");
    a_pair_even: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_ready_out && bus_req && reg_pair_in && a_lo[0] |=> reg_err_out)
        else $error("odd pair address accepted");
    a_push_predec: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        q.st == ST_PUSH |=> q.sp == $past(q.sp) - 8'h01)
        else $error("push did not lower pointer");
    a_pointer_wrap: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        q.st == ST_PUSH && q.sp == 8'h00 |=> q.sp == SP_WRAP)
        else $error("pointer did not wrap");
    a_pointer_read: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_ready_out && reg_rd_in && !reg_pair_in && a_lo == STACK_TOP_POINTER_ADDR
        |=> reg_rdata_out == $past(q.sp))
        else $error("pointer not read at its address");
    a_ret_pop: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_ret_take |=> stack_busy_out [*2] ##1 (pc_load_out && stack_done_out))
        else $error("return did not restore counter");
endmodule : addr_space_regfile

/* File: test/address_space_register_file_stack_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module address_space_register_file_stack_tb;
    import addr_space_pkg::*;
    typedef struct packed {logic [1:0] k; logic e; logic [15:0] d;} rexp_t;
    typedef struct packed {logic [2:0] w; logic [7:0] sp; logic [15:0] pc;
        logic [7:0] fl; logic [7:0] pd;} sexp_t;
    logic clk_sys_in = 0, rst_in = 1, go = 0, wr = 0;
    logic [15:0] fa = 0, reg_wd16 = 0, pc = 0, prog_addr;
    logic [7:0] fd = 0, reg_addr = 0, reg_wd = 0, flags = 0, push_data = 0, prog_wdata;
    logic reg_rd = 0, reg_wr = 0, reg_pair = 0, reg_direct = 0, prog_rd, prog_wr, fbusy;
    stack_op_t stack_op = STK_NONE;
    logic prog_ready, prog_valid, prog_err, boot_done, lvr_en, reg_ready, reg_ack, reg_err;
    logic stack_ready, stack_done, pc_load, stk_busy, prog_err4;
    logic [1:0] osc_sel;
    logic [7:0] prog_rdata, opt_lvr, opt_osc, reg_rdata, flags_o, pop_data, sp_o, prog_rdata4;
    logic [15:0] start_pc, reg_rdata16, pc_o;
    int mismatches = 0, num_checks = 0;
    logic [31:0] seed = 32'h3167b655;
    rexp_t rq[$], pq[$], r, p;
    sexp_t sq[$], s;

    core_fetch_model i_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .go_in(go),
        .wr_in(wr), .addr_in(fa), .data_in(fd), .prog_ready_in(prog_ready),
        .prog_rd_out(prog_rd), .prog_wr_out(prog_wr), .prog_addr_out(prog_addr),
        .prog_wdata_out(prog_wdata), .busy_out(fbusy));

    addr_space_regfile #(.PROG_KB(8)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .prog_addr_in(prog_addr), .prog_rd_in(prog_rd), .prog_wr_in(prog_wr),
        .prog_wdata_in(prog_wdata), .prog_ready_out(prog_ready), .prog_rdata_out(prog_rdata),
        .prog_valid_out(prog_valid), .prog_err_out(prog_err), .start_pc_out(start_pc),
        .boot_done_out(boot_done), .lvr_enable_out(lvr_en), .osc_select_out(osc_sel),
        .opt_lvr_byte_out(opt_lvr), .opt_osc_byte_out(opt_osc), .reg_addr_in(reg_addr),
        .reg_rd_in(reg_rd), .reg_wr_in(reg_wr), .reg_pair_in(reg_pair),
        .reg_direct_in(reg_direct), .reg_wdata_in(reg_wd), .reg_wdata16_in(reg_wd16),
        .reg_ready_out(reg_ready), .reg_rdata_out(reg_rdata), .reg_rdata16_out(reg_rdata16),
        .reg_ack_out(reg_ack), .reg_err_out(reg_err), .stack_op_in(stack_op), .pc_in(pc),
        .flags_in(flags), .push_data_in(push_data), .stack_ready_out(stack_ready),
        .stack_busy_out(stk_busy), .stack_done_out(stack_done), .pc_out(pc_o),
        .pc_load_out(pc_load), .flags_out(flags_o), .pop_data_out(pop_data),
        .stack_top_pointer_out(sp_o));

    // Small-flash variant, watched on its fetch answers only
    addr_space_regfile #(.PROG_KB(4)) i_dut_4k (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .prog_addr_in(prog_addr), .prog_rd_in(prog_rd), .prog_wr_in(prog_wr),
        .prog_wdata_in(prog_wdata), .prog_ready_out(), .prog_rdata_out(prog_rdata4),
        .prog_valid_out(), .prog_err_out(prog_err4), .start_pc_out(), .boot_done_out(),
        .lvr_enable_out(), .osc_select_out(), .opt_lvr_byte_out(), .opt_osc_byte_out(),
        .reg_addr_in(reg_addr), .reg_rd_in(reg_rd), .reg_wr_in(reg_wr),
        .reg_pair_in(reg_pair), .reg_direct_in(reg_direct), .reg_wdata_in(reg_wd),
        .reg_wdata16_in(reg_wd16), .reg_ready_out(), .reg_rdata_out(), .reg_rdata16_out(),
        .reg_ack_out(), .reg_err_out(), .stack_op_in(stack_op), .pc_in(pc), .flags_in(flags),
        .push_data_in(push_data), .stack_ready_out(), .stack_busy_out(), .stack_done_out(),
        .pc_out(), .pc_load_out(), .flags_out(), .pop_data_out(), .stack_top_pointer_out());

    // Clock, 25 ns period
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic do_reset();
        int n;
        @(posedge clk_sys_in) rst_in <= 1'b1;
        repeat (16) @(posedge clk_sys_in);
        `CHK(opt_lvr, 8'hFF)
        rst_in <= 1'b0;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (boot_done !== 1'b1 && n < 20);
        `CHK(n, 3)
    endtask : do_reset

    task automatic reg_op(input logic rd, wrq, pr, dr, input logic [7:0] a,
        input logic [15:0] wd, input rexp_t x);
        int n;
        @(posedge clk_sys_in);
        {reg_rd, reg_wr, reg_pair, reg_direct} <= {rd, wrq, pr, dr};
        reg_addr <= a;
        reg_wd <= wd[7:0];
        reg_wd16 <= wd;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (reg_ready !== 1'b1 && n < 50);
        rq.push_back(x);
        {reg_rd, reg_wr} <= 2'b00;
        reg_addr <= ~a;
        reg_wd16 <= ~wd;
    endtask : reg_op

    task automatic prog(input logic w, input logic [15:0] a, input logic [7:0] d,
        input logic e, input logic [7:0] ed);
        int n;
        @(posedge clk_sys_in);
        {go, wr, fa, fd} <= {1'b1, w, a, d};
        if (!w) pq.push_back('{{a > 16'h0FFF, 1'b1}, e, {8'h00, ed}});
        @(posedge clk_sys_in) go <= 1'b0;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (fbusy === 1'b1 && n < 50);
    endtask : prog

    task automatic stk(input stack_op_t op, input logic [15:0] p_in,
        input logic [7:0] f_in, input logic [7:0] d_in, input sexp_t x);
        int n;
        @(posedge clk_sys_in);
        stack_op <= op;
        {pc, flags, push_data} <= {p_in, f_in, d_in};
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (stack_ready !== 1'b1 && n < 50);
        sq.push_back(x);
        stack_op <= STK_NONE;
        pc <= ~p_in;
        @(posedge clk_sys_in);
        `CHK(stk_busy, 1'b1)
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (stack_done !== 1'b1 && n < 50);
    endtask : stk

    // Result watcher, one queued note per answer
    always @(posedge clk_sys_in) begin
        #1;
        if (reg_ack === 1'b1) begin
            r = rq.pop_front();
            `CHK(reg_err, r.e)
            if (r.k == 2'd1) `CHK(reg_rdata, r.d[7:0])
            if (r.k == 2'd2) `CHK(reg_rdata16, r.d)
        end
        if (prog_valid === 1'b1) begin
            p = pq.pop_front();
            `CHK({prog_err, prog_rdata}, {p.e, p.d[7:0]})
            `CHK({prog_err4, prog_rdata4}, p.k[1] ? 9'h100 : {p.e, p.d[7:0]})
        end
        if (stack_done === 1'b1) begin
            s = sq.pop_front();
            `CHK(sp_o, s.sp)
            `CHK(pc_load, s.w[0])
            if (s.w[0]) `CHK(pc_o, s.pc)
            if (s.w[1]) `CHK(flags_o, s.fl)
            if (s.w[2]) `CHK(pop_data, s.pd)
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        mismatches++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [7:0] a;
        do_reset();
        `CHK({lvr_en, osc_sel}, {1'b1, OSC_INTERNAL_RC})
        `CHK(start_pc, 16'h0100)
        prog(1, 16'h0000, 8'h21, 0, 0);
        prog(1, 16'h0001, 8'h43, 0, 0);
        prog(1, 16'h003C, 8'h00, 0, 0);
        prog(1, 16'h003D, 8'h00, 0, 0);
        prog(1, 16'h003E, 8'h64, 0, 0);
        prog(1, 16'h003F, 8'h02, 0, 0);
        prog(0, 16'h0001, 0, 0, 8'h43);
        prog(0, 16'h1FFF, 0, 0, 8'hFF);
        prog(0, 16'h2000, 0, 1, 8'h00);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            a = 8'(seed[15:8] % 8'd192);
            reg_op(0, 1, 0, 1, a, {8'h00, seed[7:0]}, '{2'd0, 1'b0, 16'h0});
            reg_op(1, 0, 0, 1, a, 0, '{2'd1, 1'b0, {8'h00, seed[7:0]}});
        end
        reg_op(0, 1, 1, 1, 8'h40, 16'hA55A, '{2'd0, 1'b0, 16'h0});
        reg_op(1, 0, 0, 1, 8'h40, 0, '{2'd1, 1'b0, 16'h00A5});
        reg_op(1, 0, 0, 1, 8'h41, 0, '{2'd1, 1'b0, 16'h005A});
        reg_op(1, 0, 1, 1, 8'h40, 0, '{2'd2, 1'b0, 16'hA55A});
        reg_op(0, 1, 1, 1, 8'h41, 16'h1111, '{2'd0, 1'b1, 16'h0});
        reg_op(0, 1, 0, 1, 8'hC2, 16'h0033, '{2'd0, 1'b1, 16'h0});
        reg_op(0, 1, 0, 0, 8'hC2, 16'h0077, '{2'd0, 1'b0, 16'h0});
        reg_op(1, 0, 0, 0, 8'hC2, 0, '{2'd1, 1'b0, 16'h0077});
        reg_op(1, 0, 0, 1, 8'hC2, 0, '{2'd0, 1'b1, 16'h0});
        reg_op(1, 0, 0, 1, 8'hD0, 0, '{2'd1, 1'b0, 16'h0000});
        reg_op(1, 0, 0, 1, 8'hF0, 0, '{2'd1, 1'b0, 16'h0000});
        reg_op(0, 1, 0, 1, 8'hD9, 16'h00C0, '{2'd0, 1'b0, 16'h0});
        reg_op(1, 0, 0, 1, 8'hD9, 0, '{2'd1, 1'b0, 16'h00C0});
        stk(STK_PUSH, 0, 0, 8'h5A, '{3'd0, 8'hBF, 16'h0, 8'h0, 8'h0});
        reg_op(1, 0, 0, 1, 8'hBF, 0, '{2'd1, 1'b0, 16'h005A});
        stk(STK_CALL, 16'h1234, 0, 0, '{3'd0, 8'hBD, 16'h0, 8'h0, 8'h0});
        stk(STK_RET, 0, 0, 0, '{3'd1, 8'hBF, 16'h1234, 8'h0, 8'h0});
        stk(STK_INT, 16'hABCD, 8'hF0, 0, '{3'd1, 8'hBC, 16'h2143, 8'h0, 8'h0});
        stk(STK_INTERRUPT_RETURN_OP, 0, 0, 0, '{3'd3, 8'hBF, 16'hABCD, 8'hF0, 8'h0});
        stk(STK_POP, 0, 0, 0, '{3'd4, 8'hC0, 16'h0, 8'h0, 8'h5A});
        reg_op(0, 1, 0, 1, 8'hD9, 16'h0000, '{2'd0, 1'b0, 16'h0});
        stk(STK_PUSH, 0, 0, 8'h11, '{3'd0, 8'hFF, 16'h0, 8'h0, 8'h0});
        do_reset();
        `CHK({opt_lvr, opt_osc, lvr_en, osc_sel}, {8'h64, 8'h02, 1'b0, 2'h2})
        prog(0, 16'h0000, 0, 0, 8'h21);
        repeat (5) @(posedge clk_sys_in);
        `CHK(32'(rq.size() + pq.size() + sq.size()), 32'd0)
        print_verdict();
    end
endmodule : address_space_register_file_stack_tb

/* File: test/core_fetch_model.sv */
`timescale 1ns/1ps
module core_fetch_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic wr_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic prog_ready_in,
    output logic prog_rd_out,
    output logic prog_wr_out,
    output logic [15:0] prog_addr_out,
    output logic [7:0] prog_wdata_out,
    output logic busy_out
);
    // Fetch or program one byte; fetch held until ready, released lines inverted
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            prog_rd_out <= 1'b0;
            prog_wr_out <= 1'b0;
            busy_out <= 1'b0;
        end else if (go_in) begin
            prog_rd_out <= !wr_in;
            prog_wr_out <= wr_in;
            prog_addr_out <= addr_in;
            prog_wdata_out <= data_in;
            busy_out <= 1'b1;
        end else if (prog_wr_out || (prog_rd_out && prog_ready_in)) begin
            prog_rd_out <= 1'b0;
            prog_wr_out <= 1'b0;
            busy_out <= 1'b0;
            prog_addr_out <= ~prog_addr_out;
            prog_wdata_out <= ~prog_wdata_out;
        end
    end
endmodule : core_fetch_model
